// [rtl/ssr_evt_grp.sv]
`timescale 1ns/1ps
// One condition / event / enable group with its summary bit
module ssr_evt_grp #(
    parameter int          W         = 16,
    parameter logic [W-1:0] USED_MASK = '1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] cond,
    input  wire logic [W-1:0] set_pulse,
    input  wire logic         evt_clr,
    input  wire logic         en_wr,
    input  wire logic [W-1:0] en_wdata,
    input  wire logic         en_clr,
    input  wire logic         en_init,
    input  wire logic [W-1:0] en_init_val,
    output logic      [W-1:0] cond_q,
    output logic      [W-1:0] evt_q,
    output logic      [W-1:0] en_q,
    output logic              summary
);

    logic [W-1:0] rise;
    logic [W-1:0] evt_set;
    logic [W-1:0] evt_d;
    logic [W-1:0] en_d;

    // Live condition only moves forward; a rising edge is the event
    assign rise    = cond & ~cond_q;
    assign evt_set = (rise | set_pulse) & USED_MASK;
    // Set beats clear so an event in the clearing cycle is kept
    assign evt_d   = evt_set | (evt_clr ? '0 : evt_q);
    // Power-on load first, then software write, then preset clear
    assign en_d    = en_init ? (en_init_val & USED_MASK) :
                     en_wr   ? (en_wdata & USED_MASK) :
                     en_clr  ? '0 : en_q;
    // Summary is pure logic so a cleared event drops it at once
    assign summary = |(evt_q & en_q);

    // Group storage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cond_q <= '0;
            evt_q  <= '0;
            en_q   <= '0;
        end else begin
            cond_q <= cond & USED_MASK;
            evt_q  <= evt_d;
            en_q   <= en_d;
        end
    end

endmodule

// [rtl/ssr_mav.sv]
`timescale 1ns/1ps
// Message-available tracking for the output buffer
module ssr_mav (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic obuf_push,
    input  wire logic rdg_trig,
    input  wire logic read_mode,
    input  wire logic fetch_done,
    input  wire logic obuf_read_last,
    input  wire logic query_pending,
    output logic      mav_q
);

    logic mav_set;
    logic mav_clr;
    logic mav_d;

    // Immediate readings flag on first trigger; stored ones only after fetch
    assign mav_set = obuf_push | (rdg_trig & read_mode) | fetch_done;
    // Drain alone is not enough while a query still owes an answer
    assign mav_clr = obuf_read_last & ~query_pending;
    assign mav_d   = mav_set | (mav_q & ~mav_clr);

    // Flag storage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mav_q <= 1'b0;
        end else begin
            mav_q <= mav_d;
        end
    end

endmodule

// [rtl/ssr_pkg.sv]
package ssr_pkg;

    // Register widths
    localparam int STB_W  = 8;
    localparam int ESR_W  = 8;
    localparam int QUES_W = 16;
    localparam int OPER_W = 16;
    localparam int RPL_W  = 16;

    // Status byte bit positions
    localparam int STB_QUES_BIT = 3;
    localparam int STB_MAV_BIT  = 4;
    localparam int STB_ESB_BIT  = 5;
    localparam int STB_RQS_BIT  = 6;
    localparam int STB_OPER_BIT = 7;

    // Standard event bit positions
    localparam int ESR_OPC_BIT  = 0;
    localparam int ESR_QYE_BIT  = 2;
    localparam int ESR_DDE_BIT  = 3;
    localparam int ESR_EXE_BIT  = 4;
    localparam int ESR_CME_BIT  = 5;
    localparam int ESR_PON_BIT  = 7;

    // Questionable and operational bit positions
    localparam int QUES_VOLT_BIT = 0;
    localparam int QUES_TEMP_BIT = 4;
    localparam int QUES_OHM_BIT  = 9;
    localparam int OPER_FILT_BIT = 8;

    // Implemented bits; all others always read zero
    localparam logic [ESR_W-1:0]  ESR_USED_MASK  = 8'hBD;
    localparam logic [QUES_W-1:0] QUES_USED_MASK = 16'h0213;
    localparam logic [OPER_W-1:0] OPER_USED_MASK = 16'h0100;

    // Values after reset
    localparam logic [STB_W-1:0]  STB_RST  = 8'h00;
    localparam logic [ESR_W-1:0]  ESR_RST  = 8'h00;
    localparam logic [QUES_W-1:0] QUES_RST = 16'h0000;
    localparam logic [OPER_W-1:0] OPER_RST = 16'h0000;
    localparam logic [RPL_W-1:0]  RPL_RST  = 16'h0000;

endpackage

// [rtl/ssr_status.sv]
`timescale 1ns/1ps
module ssr_status (
    input  wire logic                       clk,
    input  wire logic                       rst_b,
    // Command strobes from the command executor
    input  wire logic                       cmd_cls,
    input  wire logic                       cmd_preset,
    input  wire logic                       cmd_opc_done,
    input  wire logic                       serial_poll,
    input  wire logic                       stb_query,
    input  wire logic                       sre_query,
    input  wire logic                       sre_wr,
    input  wire logic [ssr_pkg::STB_W-1:0]  sre_wdata,
    input  wire logic                       esr_query,
    input  wire logic                       ese_query,
    input  wire logic                       ese_wr,
    input  wire logic [ssr_pkg::ESR_W-1:0]  ese_wdata,
    input  wire logic                       ques_evt_query,
    input  wire logic                       ques_cond_query,
    input  wire logic                       ques_en_query,
    input  wire logic                       ques_en_wr,
    input  wire logic [ssr_pkg::QUES_W-1:0] ques_en_wdata,
    input  wire logic                       oper_evt_query,
    input  wire logic                       oper_cond_query,
    input  wire logic                       oper_en_query,
    input  wire logic                       oper_en_wr,
    input  wire logic [ssr_pkg::OPER_W-1:0] oper_en_wdata,
    // Power-on-clear setting and retained masks from non-volatile store
    input  wire logic                       psc_flag,
    input  wire logic [ssr_pkg::STB_W-1:0]  sre_saved,
    input  wire logic [ssr_pkg::ESR_W-1:0]  ese_saved,
    // Instrument events and live conditions
    input  wire logic                       err_query,
    input  wire logic                       err_device,
    input  wire logic                       err_exec,
    input  wire logic                       err_cmd,
    input  wire logic [ssr_pkg::QUES_W-1:0] ques_cond,
    input  wire logic [ssr_pkg::OPER_W-1:0] oper_cond,
    // Output buffer activity
    input  wire logic                       obuf_push,
    input  wire logic                       rdg_trig,
    input  wire logic                       read_mode,
    input  wire logic                       fetch_done,
    input  wire logic                       obuf_read_last,
    input  wire logic                       query_pending,
    // Results
    output logic [ssr_pkg::STB_W-1:0]       status_summary_byte_q,
    output logic                            srq_q,
    output logic [ssr_pkg::STB_W-1:0]       poll_byte_q,
    output logic                            poll_valid_q,
    output logic [ssr_pkg::RPL_W-1:0]       reply_q,
    output logic                            reply_valid_q
);

    logic                       init_q;
    logic                       en_init;
    logic [ssr_pkg::STB_W-1:0]  sre_q;
    logic [ssr_pkg::STB_W-1:0]  sre_d;
    logic [ssr_pkg::STB_W-1:0]  sre_init_val;
    logic [ssr_pkg::ESR_W-1:0]  ese_init_val;
    logic [ssr_pkg::ESR_W-1:0]  esr_set;
    logic [ssr_pkg::ESR_W-1:0]  esr_q;
    logic [ssr_pkg::ESR_W-1:0]  ese_q;
    logic [ssr_pkg::QUES_W-1:0] ques_evt_q;
    logic [ssr_pkg::QUES_W-1:0] ques_en_q;
    logic [ssr_pkg::QUES_W-1:0] ques_cond_q;
    logic [ssr_pkg::OPER_W-1:0] oper_evt_q;
    logic [ssr_pkg::OPER_W-1:0] oper_en_q;
    logic [ssr_pkg::OPER_W-1:0] oper_cond_q;
    logic                       esb_sum;
    logic                       ques_sum;
    logic                       oper_sum;
    logic                       mav_q;
    logic                       esr_clr;
    logic                       ques_clr;
    logic                       oper_clr;
    logic [ssr_pkg::STB_W-1:0]  sum_byte;
    logic                       svc_req;
    logic                       svc_req_q;
    logic                       rqs_q;
    logic                       rqs_d;
    logic [ssr_pkg::STB_W-1:0]  stb_d;
    logic                       any_query;
    logic [ssr_pkg::RPL_W-1:0]  reply_d;

    // First cycle after reset release counts as power-on
    assign en_init      = ~init_q;
    // Non-volatile masks survive power cycles unless clear-at-power-on is set
    assign sre_init_val = psc_flag ? ssr_pkg::STB_RST : sre_saved;
    assign ese_init_val = psc_flag ? ssr_pkg::ESR_RST : ese_saved;

    // Standard event sources; unused bits are masked inside the group
    always_comb begin
        esr_set                       = '0;
        esr_set[ssr_pkg::ESR_OPC_BIT] = cmd_opc_done;
        esr_set[ssr_pkg::ESR_QYE_BIT] = err_query;
        esr_set[ssr_pkg::ESR_DDE_BIT] = err_device;
        esr_set[ssr_pkg::ESR_EXE_BIT] = err_exec;
        esr_set[ssr_pkg::ESR_CME_BIT] = err_cmd;
        esr_set[ssr_pkg::ESR_PON_BIT] = en_init;
    end

    // Only queries, clear-status and reset clear events; preset and power-on do not
    assign esr_clr  = cmd_cls | esr_query;
    assign ques_clr = cmd_cls | ques_evt_query;
    assign oper_clr = cmd_cls | oper_evt_query;

    // Standard event group has no live conditions
    ssr_evt_grp #(
        .W         (ssr_pkg::ESR_W),
        .USED_MASK (ssr_pkg::ESR_USED_MASK)
    ) u_esr (
        .clk         (clk),
        .rst_b       (rst_b),
        .cond        ('0),
        .set_pulse   (esr_set),
        .evt_clr     (esr_clr),
        .en_wr       (ese_wr),
        .en_wdata    (ese_wdata),
        .en_clr      (1'b0),
        .en_init     (en_init),
        .en_init_val (ese_init_val),
        .cond_q      (),
        .evt_q       (esr_q),
        .en_q        (ese_q),
        .summary     (esb_sum)
    );

    // Questionable group: enable always clears at power-on; preset clears it unless ques_en_wr comes in the same cycle
    ssr_evt_grp #(
        .W         (ssr_pkg::QUES_W),
        .USED_MASK (ssr_pkg::QUES_USED_MASK)
    ) u_ques (
        .clk         (clk),
        .rst_b       (rst_b),
        .cond        (ques_cond),
        .set_pulse   ('0),
        .evt_clr     (ques_clr),
        .en_wr       (ques_en_wr),
        .en_wdata    (ques_en_wdata),
        .en_clr      (cmd_preset),
        .en_init     (en_init),
        .en_init_val (ssr_pkg::QUES_RST),
        .cond_q      (ques_cond_q),
        .evt_q       (ques_evt_q),
        .en_q        (ques_en_q),
        .summary     (ques_sum)
    );

    // Operational group: only the filter-settled bit is live
    ssr_evt_grp #(
        .W         (ssr_pkg::OPER_W),
        .USED_MASK (ssr_pkg::OPER_USED_MASK)
    ) u_oper (
        .clk         (clk),
        .rst_b       (rst_b),
        .cond        (oper_cond),
        .set_pulse   ('0),
        .evt_clr     (oper_clr),
        .en_wr       (oper_en_wr),
        .en_wdata    (oper_en_wdata),
        .en_clr      (1'b0),
        .en_init     (en_init),
        .en_init_val (ssr_pkg::OPER_RST),
        .cond_q      (oper_cond_q),
        .evt_q       (oper_evt_q),
        .en_q        (oper_en_q),
        .summary     (oper_sum)
    );

    // Output buffer message tracking
    ssr_mav u_mav (
        .clk            (clk),
        .rst_b          (rst_b),
        .obuf_push      (obuf_push),
        .rdg_trig       (rdg_trig),
        .read_mode      (read_mode),
        .fetch_done     (fetch_done),
        .obuf_read_last (obuf_read_last),
        .query_pending  (query_pending),
        .mav_q          (mav_q)
    );

    // Summary bits without request service; low three bits stay zero
    always_comb begin
        sum_byte                        = '0;
        sum_byte[ssr_pkg::STB_QUES_BIT] = ques_sum;
        sum_byte[ssr_pkg::STB_MAV_BIT]  = mav_q;
        sum_byte[ssr_pkg::STB_ESB_BIT]  = esb_sum;
        sum_byte[ssr_pkg::STB_OPER_BIT] = oper_sum;
    end

    // Service wanted when any enabled summary is up; own bit excluded
    assign svc_req = |(sum_byte & sre_q & ~(ssr_pkg::STB_W'(1) << ssr_pkg::STB_RQS_BIT));
    // New requests come from a rising service condition so a poll really clears it;
    // a cleared cause drops it too, and the poll never blocks a new rising edge
    assign rqs_d = (svc_req & ~svc_req_q) |
                   (rqs_q & svc_req & ~serial_poll);

    // Live status byte with request service inserted
    always_comb begin
        stb_d                       = sum_byte;
        stb_d[ssr_pkg::STB_RQS_BIT] = rqs_q;
    end

    // Service-request enable: zero write clears, power-on follows the setting
    assign sre_d = en_init ? sre_init_val :
                   sre_wr  ? sre_wdata : sre_q;

    // Query answers; executor issues one query per cycle, in command order
    assign any_query = stb_query | sre_query | esr_query | ese_query |
                       ques_evt_query | ques_cond_query | ques_en_query |
                       oper_evt_query | oper_cond_query | oper_en_query;
    assign reply_d = stb_query       ? byte_ext(stb_d) :
                     sre_query       ? byte_ext(sre_q) :
                     esr_query       ? byte_ext(esr_q) :
                     ese_query       ? byte_ext(ese_q) :
                     ques_evt_query  ? ques_evt_q :
                     ques_cond_query ? ques_cond_q :
                     ques_en_query   ? ques_en_q :
                     oper_evt_query  ? oper_evt_q :
                     oper_cond_query ? oper_cond_q :
                     oper_en_query   ? oper_en_q : reply_q;

    // Zero-extend a byte to the reply width
    function automatic logic [ssr_pkg::RPL_W-1:0] byte_ext(input logic [7:0] b);
        byte_ext = {8'h00, b};
    endfunction

    // Power-on marker and service-request mask
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            init_q <= 1'b0;
            sre_q  <= ssr_pkg::STB_RST;
        end else begin
            init_q <= 1'b1;
            sre_q  <= sre_d;
        end
    end

    // Request service and the SRQ line move together every cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            svc_req_q <= 1'b0;
            rqs_q     <= 1'b0;
            srq_q     <= 1'b0;
        end else begin
            svc_req_q <= svc_req;
            rqs_q     <= rqs_d;
            srq_q     <= rqs_d;
        end
    end

    // Registered status byte; event-enable writes show one cycle later, service-request mask writes two cycles later
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status_summary_byte_q <= ssr_pkg::STB_RST;
        end else begin
            status_summary_byte_q <= stb_d;
        end
    end

    // Serial poll answer is taken straight from live bits, no queueing,
    // so measurement never waits for it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            poll_byte_q  <= ssr_pkg::STB_RST;
            poll_valid_q <= 1'b0;
        end else begin
            poll_valid_q <= serial_poll;
            if (serial_poll) begin
                poll_byte_q <= stb_d;
            end
        end
    end

    // Command query answer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reply_q       <= ssr_pkg::RPL_RST;
            reply_valid_q <= 1'b0;
        end else begin
            reply_q       <= reply_d;
            reply_valid_q <= any_query;
        end
    end

endmodule

// [test/ssr_ctrl_model.sv]
`timescale 1ns/1ps
// Bus controller: serial polls and queries, one strobe per request
module ssr_ctrl_model (
    input  wire logic        clk,
    output logic      [10:0] strb,
    input  wire logic [7:0]  poll_byte_q,
    input  wire logic        poll_valid_q,
    input  wire logic [15:0] reply_q,
    input  wire logic        reply_valid_q
);
    initial strb = 11'h000;

    // Request k (0 is a poll); a missing answer leaves v unknown
    task automatic ask(input int k, output logic [15:0] v);
        v = 'x;
        @(posedge clk);
        strb <= 11'h001 << k;
        @(posedge clk);
        strb <= 11'h000;
        // Answer stands one cycle only, so look just after the taking edge first
        for (int n = 0; n < 4; n++) begin
            #1;
            if (k == 0 && poll_valid_q === 1'b1) begin
                v = {8'h00, poll_byte_q};
                break;
            end
            if (k != 0 && reply_valid_q === 1'b1) begin
                v = reply_q;
                break;
            end
            @(posedge clk);
        end
    endtask
endmodule

// [test/ssr_status_assertions.sv]
`timescale 1ns/1ps
// Port-level checks on the status block
module ssr_status_assertions (
    input wire logic                       clk,
    input wire logic                       rst_b,
    input wire logic                       serial_poll,
    input wire logic                       stb_query,
    input wire logic                       cmd_cls,
    input wire logic                       cmd_opc_done,
    input wire logic                       err_query,
    input wire logic                       err_device,
    input wire logic                       err_exec,
    input wire logic                       err_cmd,
    input wire logic [ssr_pkg::QUES_W-1:0] ques_cond,
    input wire logic [ssr_pkg::OPER_W-1:0] oper_cond,
    input wire logic                       obuf_push,
    input wire logic                       rdg_trig,
    input wire logic                       read_mode,
    input wire logic                       fetch_done,
    input wire logic                       obuf_read_last,
    input wire logic                       query_pending,
    input wire logic [ssr_pkg::STB_W-1:0]  status_summary_byte_q,
    input wire logic                       srq_q,
    input wire logic                       poll_valid_q,
    input wire logic [ssr_pkg::RPL_W-1:0]  reply_q,
    input wire logic                       reply_valid_q
);
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    logic       ev;
    logic       mav_set;
    logic       rd_done;
    logic [2:0] calm_q;

    // Event sources, buffer fill and buffer drain
    assign ev      = err_query | err_device | err_exec | err_cmd | cmd_opc_done;
    assign mav_set = obuf_push | fetch_done | (rdg_trig & read_mode);
    assign rd_done = obuf_read_last & ~query_pending;

    // Quiet-cycle count; a late event set would hide a missed clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            calm_q <= 3'h0;
        end else if (ev || !$stable(ques_cond) || !$stable(oper_cond)) begin
            calm_q <= 3'h0;
        end else if (calm_q != 3'h7) begin
            calm_q <= calm_q + 3'h1;
        end
    end

    low_bits_zero_a:
        assert property (status_summary_byte_q[2:0] == 3'h0) else $error("low bits set");
    poll_answer_a:
        assert property (serial_poll |=> poll_valid_q && !srq_q) else $error("poll answer");
    poll_cause_a:
        assert property (poll_valid_q |-> $past(serial_poll)) else $error("stray poll");
    query_answer_a:
        assert property (stb_query |=> reply_valid_q && reply_q[15:8] == 8'h00)
        else $error("byte query answer");
    cls_clears_a:
        assert property (cmd_cls ##2 calm_q > 3'h4 |=> (status_summary_byte_q & 8'hA8) == 8'h00)
        else $error("summary kept after clear");
    mav_sets_a:
        assert property (mav_set ##1 !obuf_read_last |-> ##[1:2] status_summary_byte_q[4])
        else $error("message bit not set");
    mav_cause_a:
        assert property ($rose(status_summary_byte_q[4]) |-> $past(mav_set, 2) || $past(mav_set, 3))
        else $error("message bit set without data");
    mav_clear_a:
        assert property ($fell(status_summary_byte_q[4]) |-> $past(rd_done, 2) || $past(rd_done, 3))
        else $error("message bit cleared early");

    // Main scenarios reached
    poll_srq_c: cover property (serial_poll && srq_q);
    mav_rise_c: cover property ($rose(status_summary_byte_q[4]));
    cls_c: cover property (cmd_cls);
endmodule

bind ssr_status ssr_status_assertions i_ssr_status_assertions (
    .clk, .rst_b, .serial_poll, .stb_query, .cmd_cls, .cmd_opc_done, .err_query,
    .err_device, .err_exec, .err_cmd, .ques_cond, .oper_cond, .obuf_push, .rdg_trig,
    .read_mode, .fetch_done, .obuf_read_last, .query_pending, .status_summary_byte_q,
    .srq_q, .poll_valid_q, .reply_q, .reply_valid_q
);

// [test/test_scpi_status_reporting.sv]
`timescale 1ns/1ps
// Self-checking bench for the status block
module test_scpi_status_reporting;
    localparam int POLL = 0, STB = 1, SRE = 2, ESR = 3, ESE = 4, QEV = 5, QCN = 6, QEN = 7;
    localparam int OCN = 9, OEN = 10, CLS = 0, PRE = 1, OPC = 2, SRW = 3, ESW = 4, QEW = 5;
    localparam int OEW = 6, ECMD = 7, PUSH = 11, TRIG = 12, FETCH = 13, RLAST = 14;

    logic        clk, rst_b, psc_flag, read_mode, query_pending, srq_q, poll_valid_q;
    logic        reply_valid_q;
    logic [14:0] p;
    logic [10:0] strb;
    logic [15:0] wd, ques_cond, oper_cond, reply_q, v;
    logic [7:0]  sre_saved, ese_saved, stb_q, poll_byte_q;
    int          fails, total_checks;

    ssr_status i_ssr_status (
        .clk, .rst_b, .cmd_cls(p[CLS]), .cmd_preset(p[PRE]), .cmd_opc_done(p[OPC]),
        .serial_poll(strb[POLL]), .stb_query(strb[STB]), .sre_query(strb[SRE]),
        .sre_wr(p[SRW]), .sre_wdata(wd[7:0]), .esr_query(strb[ESR]), .ese_query(strb[ESE]),
        .ese_wr(p[ESW]), .ese_wdata(wd[7:0]), .ques_evt_query(strb[QEV]),
        .ques_cond_query(strb[QCN]), .ques_en_query(strb[QEN]), .ques_en_wr(p[QEW]),
        .ques_en_wdata(wd), .oper_evt_query(strb[8]), .oper_cond_query(strb[OCN]),
        .oper_en_query(strb[OEN]), .oper_en_wr(p[OEW]), .oper_en_wdata(wd), .psc_flag,
        .sre_saved, .ese_saved, .err_query(p[8]), .err_device(p[9]), .err_exec(p[10]),
        .err_cmd(p[ECMD]), .ques_cond, .oper_cond, .obuf_push(p[PUSH]), .rdg_trig(p[TRIG]),
        .read_mode, .fetch_done(p[FETCH]), .obuf_read_last(p[RLAST]), .query_pending,
        .status_summary_byte_q(stb_q), .srq_q, .poll_byte_q, .poll_valid_q, .reply_q,
        .reply_valid_q
    );

    ssr_ctrl_model i_ssr_ctrl_model (
        .clk, .strb, .poll_byte_q, .poll_valid_q, .reply_q, .reply_valid_q
    );

    // 100 MHz clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    // Shared compare, one-cycle strobe, settle wait and controller request
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic pul(input int k, input logic [15:0] d);
        @(posedge clk);
        p <= 15'h0001 << k;
        wd <= d;
        @(posedge clk);
        p <= 15'h0000;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic ask(input int k, input logic [15:0] exp);
        i_ssr_ctrl_model.ask(k, v);
        chk(v, exp);
    endtask

    // Reset low across 8 edges; status byte must read zero meanwhile
    task automatic do_reset();
        @(posedge clk);
        rst_b <= 1'b0;
        wt(7);
        chk({8'h00, stb_q}, 16'h0000);
        @(posedge clk);
        rst_b <= 1'b1;
    endtask

    // Saved masks kept; power-on event raises service until its event is read
    task automatic t_power();
        ask(SRE, 16'h0028);
        ask(ESE, 16'h0081);
        chk({8'h00, stb_q}, 16'h0060);
        ask(ESR, 16'h0080);
        wt(3);
        chk({7'h00, srq_q, stb_q}, 16'h0000);
        ask(ESR, 16'h0000);
        @(posedge clk);
        psc_flag <= 1'b1;
        do_reset();
        ask(SRE, 16'h0000);
        ask(ESE, 16'h0000);
    endtask

    // Condition rise latches, survives the fall, clears on query
    task automatic t_ques();
        pul(QEW, 16'hFFFF);
        ask(QEN, 16'h0213);
        @(posedge clk);
        ques_cond <= 16'h0201;
        wt(5);
        chk({8'h00, stb_q}, 16'h0008);
        @(posedge clk);
        ques_cond <= 16'h0000;
        ask(QCN, 16'h0000);
        chk({8'h00, stb_q}, 16'h0008);
        ask(QEV, 16'h0201);
        wt(2);
        chk({8'h00, stb_q}, 16'h0000);
    endtask

    // Completion polling: enable, complete, query, poll, read the cause
    task automatic t_srq();
        pul(CLS, 16'h0000);
        pul(ESW, 16'h0001);
        pul(SRW, 16'h0020);
        pul(OPC, 16'h0000);
        wt(3);
        chk({15'h0000, srq_q}, 16'h0001);
        ask(STB, 16'h0060);
        chk({15'h0000, srq_q}, 16'h0001);
        ask(POLL, 16'h0060);
        // Status byte shows the cleared request one cycle after the poll answer
        wt(1);
        chk({7'h00, srq_q, stb_q}, 16'h0020);
        ask(ESR, 16'h0001);
        wt(2);
        chk({8'h00, stb_q}, 16'h0000);
        pul(SRW, 16'h0000);
        ask(SRE, 16'h0000);
    endtask

    // Clear-status empties events and keeps enable masks
    task automatic t_cls();
        pul(ESW, 16'h00FF);
        ask(ESE, 16'h00BD);
        for (int k = ECMD; k < 11; k++) pul(k, 16'h0000);
        ask(ESR, 16'h003C);
        pul(ECMD, 16'h0000);
        wt(6);
        chk({8'h00, stb_q}, 16'h0020);
        pul(CLS, 16'h0000);
        wt(3);
        chk({8'h00, stb_q}, 16'h0000);
        ask(ESR, 16'h0000);
        ask(ESE, 16'h00BD);
    endtask

    // Preset drops the questionable mask; operational path reaches bit 7
    task automatic t_preset();
        pul(PRE, 16'h0000);
        ask(QEN, 16'h0000);
        pul(OEW, 16'h0100);
        oper_cond <= 16'h0100;
        wt(5);
        chk({8'h00, stb_q}, 16'h0080);
        ask(OCN, 16'h0100);
        ask(OEN, 16'h0100);
    endtask

    // Message bit for stored, fetched and immediate readings
    task automatic mav_step(input int k, input logic e);
        pul(k, 16'h0000);
        wt(3);
        chk({15'h0000, stb_q[4]}, {15'h0000, e});
    endtask
    task automatic t_mav();
        mav_step(TRIG, 1'b0);
        mav_step(FETCH, 1'b1);
        @(posedge clk);
        query_pending <= 1'b1;
        mav_step(RLAST, 1'b1);
        @(posedge clk);
        query_pending <= 1'b0;
        mav_step(RLAST, 1'b0);
        @(posedge clk);
        read_mode <= 1'b1;
        mav_step(TRIG, 1'b1);
        mav_step(RLAST, 1'b0);
        mav_step(PUSH, 1'b1);
    endtask

    // Verdict
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {fails, total_checks} = '0;
        {rst_b, psc_flag, read_mode, query_pending, p, wd, ques_cond, oper_cond} = '0;
        sre_saved = 8'h28;
        ese_saved = 8'h81;
        do_reset();
        t_power();
        t_ques();
        t_srq();
        t_cls();
        t_preset();
        t_mav();
        finish_test();
    end

    // Hang guard, far beyond the expected run
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        finish_test();
    end
endmodule
